// ---- pid_speed_regulator.sv ----
// Notes on behaviour
// - regulation inactive without assigned feedback
// - feedback from inputs one-four, frequency, encoder
// - base setpoint internal or channel A
// - two select inputs pick presets
// - scaling limits above 32767 rejected
// - wake after low-speed stop on error
// - reversal flips sign of correction
// - integral term shorted by input
// - feedback alarm on logic output
// - error alarm on logic output
// - startup ramp only on start, wake
// - manual input picks preset or manual
// - predictive speed initialises on restart
// - network feedback held in forced local
`timescale 1ns/100ps
module pid_speed_regulator
  import pid_reg_pkg::*;
#(
  parameter int LOW_SPEED_LIMIT = LOW_SPEED_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] feedback_source_select,
  input wire logic [3:0] card_present,
  input wire logic signed [15:0] analog_in1,
  input wire logic signed [15:0] analog_in2,
  input wire logic signed [15:0] analog_in3,
  input wire logic signed [15:0] analog_in4,
  input wire logic signed [15:0] freq_in,
  input wire logic signed [15:0] encoder_in,
  input wire logic signed [15:0] network_in,
  input wire logic forced_local,
  input wire logic internal_setpoint_enable,
  input wire logic signed [15:0] internal_setpoint,
  input wire logic signed [15:0] reference_channel_a,
  input wire logic signed [15:0] preset_setpoint_two,
  input wire logic signed [15:0] preset_setpoint_three,
  input wire logic signed [15:0] preset_setpoint_four,
  input wire logic preset_select_low_input,
  input wire logic preset_select_high_input,
  input wire logic scale_write,
  input wire logic [1:0] scale_index,
  input wire logic [15:0] scale_value,
  input wire logic signed [15:0] wake_error_threshold,
  input wire logic low_speed_active,
  input wire logic correction_reverse,
  input wire logic integral_bypass,
  input wire logic [GAIN_W-1:0] proportional_gain,
  input wire logic [GAIN_W-1:0] integral_gain,
  input wire logic [GAIN_W-1:0] derivative_gain,
  input wire logic signed [15:0] feedback_alarm_level,
  input wire logic signed [15:0] error_alarm_level,
  input wire logic manual_mode,
  input wire logic signed [15:0] preset_speed,
  input wire logic signed [15:0] manual_reference_source,
  input wire logic predictive_enable,
  input wire logic signed [15:0] predictive_speed_source,
  input wire logic run,
  output logic signed [15:0] speed_reference,
  output logic regulator_active,
  output logic sleeping,
  output logic startup_accel_ramp,
  output logic feedback_alarm,
  output logic error_alarm,
  output logic scale_reject,
  output logic [15:0] feedback_scale_min,
  output logic [15:0] feedback_scale_max,
  output logic [15:0] setpoint_scale_min,
  output logic [15:0] setpoint_scale_max
);
  typedef enum logic [1:0] {IDLE, START, REGULATE, SLEEP} phase_e;

  typedef struct packed {
    phase_e phase;
    logic signed [15:0] fb_hold;
    logic signed [15:0] prev_err;
    logic signed [ACC_W-1:0] integ;
    logic [ACC_W-1:0] low_cnt;
    logic signed [15:0] speed;
    logic active;
    logic sleep;
    logic accel;
    logic fb_alarm;
    logic err_alarm;
    logic reject;
    logic [15:0] fb_min;
    logic [15:0] fb_max;
    logic [15:0] sp_min;
    logic [15:0] sp_max;
  } state_s;

  state_s st;
  state_s next_st;
  logic rst_meta;
  logic rst_sync;

  function automatic logic signed [15:0] sat16(
    input logic signed [ACC_W-1:0] v
  );
    if (v > 32'sh0000_7FFF) begin
      sat16 = 16'sh7FFF;
    end else if (v < -32'sh0000_8000) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  function automatic logic signed [15:0] mag(input logic signed [15:0] v);
    mag = (v < 0) ? sat16(-ACC_W'(v)) : v;
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  logic fb_ok;
  logic signed [15:0] fb_val;
  logic signed [15:0] setpoint;
  logic signed [15:0] err;
  logic signed [15:0] corr;
  logic signed [ACC_W-1:0] p_term;
  logic signed [ACC_W-1:0] d_term;
  logic signed [ACC_W-1:0] i_next;
  logic signed [ACC_W-1:0] pid_sum;

  always_comb begin
    // optional sources need their extension card
    // feedback source mux
    fb_ok = 1'b1;
    fb_val = st.fb_hold;
    unique case (feedback_source_select)
      FB_NONE: fb_ok = 1'b0;
      FB_AI1: fb_val = analog_in1;
      FB_AI2: fb_val = analog_in2;
      FB_AI3: begin
        fb_ok = card_present[0];
        fb_val = analog_in3;
      end
      FB_AI4: begin
        fb_ok = card_present[0];
        fb_val = analog_in4;
      end
      FB_FREQ: begin
        fb_ok = card_present[0];
        fb_val = freq_in;
      end
      FB_ENC: begin
        fb_ok = card_present[1];
        fb_val = encoder_in;
      end
      FB_NET: begin
        fb_val = forced_local ? st.fb_hold : network_in;
      end
    endcase
    setpoint = internal_setpoint_enable ? internal_setpoint
                                        : reference_channel_a;
    unique case ({preset_select_high_input, preset_select_low_input})
      2'b01: setpoint = preset_setpoint_two;
      2'b10: setpoint = preset_setpoint_three;
      2'b11: setpoint = preset_setpoint_four;
      default: ;
    endcase
    err = sat16(ACC_W'(setpoint) - ACC_W'(fb_val));
    corr = correction_reverse ? sat16(-ACC_W'(err)) : err;
    p_term = (ACC_W'(corr) * $signed({1'b0, proportional_gain}))
             >>> GAIN_SHIFT;
    d_term = ((ACC_W'(corr) - ACC_W'(st.prev_err))
             * $signed({1'b0, derivative_gain})) >>> GAIN_SHIFT;
    i_next = st.integ + ((ACC_W'(corr) * $signed({1'b0, integral_gain}))
             >>> GAIN_SHIFT);
    // clamp bounds wind-up at +/-INTEG_LIMIT, output saturated or not
    if (i_next > $signed(INTEG_LIMIT)) begin
      i_next = $signed(INTEG_LIMIT);
    end else if (i_next < -$signed(INTEG_LIMIT)) begin
      i_next = -$signed(INTEG_LIMIT);
    end
    if (integral_bypass) begin
      i_next = '0;
    end
    pid_sum = p_term + d_term + (i_next >>> GAIN_SHIFT);
  end

  always_comb begin
    next_st = st;
    next_st.reject = 1'b0;
    if (fb_ok && !(feedback_source_select == FB_NET && forced_local)) begin
      next_st.fb_hold = fb_val;
    end
    if (scale_write) begin
      if (scale_value > SCALE_LIMIT) begin
        next_st.reject = 1'b1;
      end else begin
        unique case (scale_index)
          2'h0: next_st.fb_min = scale_value;
          2'h1: next_st.fb_max = scale_value;
          2'h2: next_st.sp_min = scale_value;
          2'h3: next_st.sp_max = scale_value;
        endcase
      end
    end
    next_st.fb_alarm = fb_ok && (fb_val > feedback_alarm_level);
    next_st.err_alarm = fb_ok && (mag(err) > error_alarm_level);
    next_st.accel = 1'b0;
    if (!fb_ok || !run) begin
      next_st.phase = IDLE;
      next_st.integ = '0;
      next_st.prev_err = '0;
      next_st.low_cnt = '0;
      next_st.speed = '0;
      next_st.active = 1'b0;
      next_st.sleep = 1'b0;
    end else begin
      unique case (st.phase)
        IDLE: begin
          next_st.phase = START;
          next_st.active = 1'b1;
          next_st.accel = 1'b1;
          next_st.speed = predictive_enable ? predictive_speed_source
                                            : 16'sh0000;
          next_st.integ = predictive_enable
            ? (ACC_W'(predictive_speed_source) <<< GAIN_SHIFT) : '0;
        end
        START, REGULATE: begin
          next_st.accel = (st.phase == START);
          next_st.phase = REGULATE;
          next_st.integ = i_next;
          next_st.prev_err = corr;
          next_st.speed = manual_mode
            ? sat16(pid_sum + ACC_W'(manual_reference_source)) : preset_speed;
          next_st.low_cnt = low_speed_active ? st.low_cnt + 1 : '0;
          if (st.low_cnt >= ACC_W'(LOW_SPEED_LIMIT - 1)) begin
            next_st.phase = SLEEP;
            next_st.sleep = 1'b1;
            next_st.speed = '0;
            next_st.low_cnt = '0;
          end
        end
        SLEEP: begin
          if (mag(err) > wake_error_threshold) begin
            next_st.phase = START;
            next_st.sleep = 1'b0;
            next_st.accel = 1'b1;
            next_st.integ = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      st <= '{phase: IDLE, fb_min: RESET_SCALE_MIN,
              fb_max: RESET_SCALE_MAX, sp_min: RESET_SCALE_MIN,
              sp_max: RESET_SCALE_MAX, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign speed_reference = st.speed;
  assign regulator_active = st.active;
  assign sleeping = st.sleep;
  assign startup_accel_ramp = st.accel;
  assign feedback_alarm = st.fb_alarm;
  assign error_alarm = st.err_alarm;
  assign scale_reject = st.reject;
  assign feedback_scale_min = st.fb_min;
  assign feedback_scale_max = st.fb_max;
  assign setpoint_scale_min = st.sp_min;
  assign setpoint_scale_max = st.sp_max;

  AST_INACTIVE: assert property (@(posedge clk) disable iff (!rst_sync)
    (feedback_source_select == FB_NONE) |=> !regulator_active)
    else $error("regulator active with no feedback");
  AST_SCALE_REJ: assert property (@(posedge clk) disable iff (!rst_sync)
    (scale_write && scale_value > SCALE_LIMIT) |=>
      scale_reject && $stable(feedback_scale_min)
      && $stable(setpoint_scale_max))
    else $error("oversize scale value accepted");
  sequence sleep_err_s;
    sleeping && fb_ok && run && mag(err) > wake_error_threshold;
  endsequence
  AST_WAKE: assert property (@(posedge clk) disable iff (!rst_sync)
    sleep_err_s |=> !sleeping ##1 regulator_active)
    else $error("no wake after large error");
  AST_ACCEL: assert property (@(posedge clk) disable iff (!rst_sync)
    startup_accel_ramp && $past(startup_accel_ramp) && fb_ok && run
      |=> !startup_accel_ramp)
    else $error("start ramp misbehaves");
  AST_BYPASS: assert property (@(posedge clk) disable iff (!rst_sync)
    (integral_bypass && st.phase == REGULATE && fb_ok && run)
      |=> st.integ == '0)
    else $error("integral not shorted");
  AST_FB_ALARM: assert property (@(posedge clk) disable iff (!rst_sync)
    (fb_ok && fb_val > feedback_alarm_level) |=> feedback_alarm)
    else $error("feedback alarm missed");
  AST_ERR_ALARM: assert property (@(posedge clk) disable iff (!rst_sync)
    (fb_ok && mag(err) > error_alarm_level) |=> error_alarm)
    else $error("error alarm missed");
  AST_AUTO: assert property (@(posedge clk) disable iff (!rst_sync)
    (st.phase == REGULATE && fb_ok && run && !manual_mode
      && !(st.low_cnt >= ACC_W'(LOW_SPEED_LIMIT - 1)))
      |=> speed_reference == $past(preset_speed))
    else $error("automatic speed not from presets");
endmodule

// ---- pid_reg_pkg.sv ----
package pid_reg_pkg;
  localparam int VAL_W = 16;
  localparam int ACC_W = 32;
  localparam int GAIN_W = 8;
  localparam logic [15:0] SCALE_LIMIT = 16'h7FFF;
  localparam logic [2:0] FB_NONE = 3'h0;
  localparam logic [2:0] FB_AI1 = 3'h1;
  localparam logic [2:0] FB_AI2 = 3'h2;
  localparam logic [2:0] FB_AI3 = 3'h3;
  localparam logic [2:0] FB_AI4 = 3'h4;
  localparam logic [2:0] FB_FREQ = 3'h5;
  localparam logic [2:0] FB_ENC = 3'h6;
  localparam logic [2:0] FB_NET = 3'h7;
  localparam int GAIN_SHIFT = 4;
  localparam logic [ACC_W-1:0] INTEG_LIMIT = 32'h0007_FFFF;
  localparam logic [15:0] RESET_SCALE_MIN = 16'h0064;
  localparam logic [15:0] RESET_SCALE_MAX = 16'h03E8;
  localparam int LOW_SPEED_TIME_US = 1000;
  localparam int CLK_MHZ = 25;
  localparam int LOW_SPEED_CYCLES = LOW_SPEED_TIME_US * CLK_MHZ;
endpackage

// ---- process_plant.sv ----
`timescale 1ns/100ps
module process_plant (
  input wire logic clk,
  input wire logic signed [15:0] level,
  input wire logic signed [15:0] speed_reference,
  output logic signed [15:0] sense,
  output logic low_speed_active
);
  // sensor lags the process by one cycle
  always_ff @(posedge clk) begin
    sense <= level;
    low_speed_active <= (speed_reference < 16) && (speed_reference > -16);
  end
endmodule

// ---- pid_speed_regulator_tb.sv ----
`timescale 1ns/100ps
module pid_speed_regulator_tb;
  import pid_reg_pkg::*;
  localparam logic signed [15:0] HI = 16'h0384;
  localparam logic signed [15:0] LO = 16'h0096;
  logic clk = '0, resetn = '0, run = '0, forced_local = '0, scale_write = '0;
  logic internal_setpoint_enable = '0, correction_reverse = '0;
  logic preset_select_low_input = '0, preset_select_high_input = '0;
  logic integral_bypass = '0, manual_mode = 1'h1, predictive_enable = '0;
  logic [2:0] feedback_source_select = '0;
  logic [3:0] card_present = 4'h3;
  logic [1:0] scale_index = '0;
  logic [15:0] scale_value = '0;
  logic [GAIN_W-1:0] proportional_gain = 8'h10, integral_gain = '0;
  logic [GAIN_W-1:0] derivative_gain = '0;
  logic signed [15:0] analog_in1, analog_in2, analog_in3, analog_in4;
  logic signed [15:0] freq_in, encoder_in, sense, level = 16'h01F4;
  logic signed [15:0] network_in = '0, internal_setpoint = '0;
  logic signed [15:0] reference_channel_a = '0, preset_setpoint_two = '0;
  logic signed [15:0] preset_setpoint_three = '0, preset_setpoint_four = '0;
  logic signed [15:0] wake_error_threshold = 16'h0032, preset_speed = '0;
  logic signed [15:0] feedback_alarm_level = '0, error_alarm_level = '0;
  logic signed [15:0] manual_reference_source = '0;
  logic signed [15:0] predictive_speed_source = '0, speed_reference;
  logic low_speed_active, regulator_active, sleeping, startup_accel_ramp;
  logic feedback_alarm, error_alarm, scale_reject, pos;
  logic [15:0] feedback_scale_min, feedback_scale_max;
  logic [15:0] setpoint_scale_min, setpoint_scale_max;
  int n_mismatch = 0, n_checks = 0, n_accel = 0, n_reject = 0;

  assign {analog_in1, analog_in2, analog_in3, analog_in4, freq_in,
    encoder_in} = {6{sense}};
  assign pos = speed_reference > 16'sh0000;
  always #20 clk = ~clk;
  // pulses counted at the edge; reject stands one cycle, the start ramp two
  always @(posedge clk) begin
    if (startup_accel_ramp === 1'h1) n_accel++;
    if (scale_reject === 1'h1) n_reject++;
  end

  process_plant plant (.clk(clk), .level(level),
    .speed_reference(speed_reference), .sense(sense),
    .low_speed_active(low_speed_active));
  pid_speed_regulator #(.LOW_SPEED_LIMIT(8)) uut (.*);

  task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // bounded wait on active (sel 0) or sleeping (sel 1)
  task automatic await(input int sel, input logic v);
    for (int i = 0; i < 40; i++) begin
      if ((sel == 0 ? regulator_active : sleeping) === v) return;
      tick(1);
    end
    n_mismatch++;
    $display("[ERR] wait %0d expected %h seen timeout", sel, v);
    wrap_up();
  endtask

  task automatic wr(input logic [1:0] i, input logic [15:0] v);
    scale_index = i;
    scale_value = v;
    scale_write = 1'h1;
    tick(1);
    scale_write = 1'h0;
    tick(2);
  endtask

  task automatic set_sp(input int k);
    internal_setpoint = (k == 0) ? HI : LO;
    reference_channel_a = (k == 1) ? HI : LO;
    preset_setpoint_two = (k == 2) ? HI : LO;
    preset_setpoint_three = (k == 3) ? HI : LO;
    preset_setpoint_four = (k == 4) ? HI : LO;
    internal_setpoint_enable = (k == 0);
    preset_select_low_input = (k == 2 || k == 4);
    preset_select_high_input = (k >= 3);
  endtask

  task automatic t_scale;
    int r = n_reject;
    check("fb_min", 16'h0064, feedback_scale_min);
    check("sp_max", 16'h03E8, setpoint_scale_max);
    check("sp_min", 16'h0064, setpoint_scale_min);
    wr(2'h1, 16'h8000);
    check("reject", r + 1, n_reject);
    check("fb_max", 16'h03E8, feedback_scale_max);
    wr(2'h1, 16'h7FFF);
    check("fb_max", 16'h7FFF, feedback_scale_max);
    check("reject", r + 1, n_reject);
    wr(2'h1, 16'h03E8);
  endtask

  task automatic t_sources;
    run = 1'h1;
    tick(10);
    check("idle", 1'h0, regulator_active);
    for (int s = 1; s < 7; s++) begin
      feedback_source_select = 3'(s);
      card_present = 4'h0;
      await(0, s <= 2);
      card_present = 4'h3;
      await(0, 1'h1);
    end
    feedback_source_select = FB_AI1;
  endtask

  task automatic t_start;
    int a;
    run = 1'h0;
    predictive_enable = 1'h1;
    predictive_speed_source = 16'h0123;
    await(0, 1'h0);
    a = n_accel;
    run = 1'h1;
    await(0, 1'h1);
    check("predict", 16'h0123, speed_reference);
    tick(3);
    check("accel", 1'h1, n_accel > a);
    a = n_accel;
    predictive_enable = 1'h0;
    tick(10);
    check("accel", a, n_accel);
  endtask

  task automatic t_signs;
    for (int k = 0; k < 5; k++) begin
      set_sp(k);
      for (int r = 0; r < 2; r++) begin
        correction_reverse = r[0];
        tick(4);
        check("sign", !r[0], pos);
      end
    end
    correction_reverse = 1'h0;
    set_sp(0);
  endtask

  task automatic t_network;
    network_in = 16'h01F4;
    feedback_source_select = FB_NET;
    tick(4);
    forced_local = 1'h1;
    tick(2);
    network_in = 16'h07D0;
    tick(4);
    check("net_hold", 1'h1, pos);
    forced_local = 1'h0;
    tick(4);
    check("net_live", 1'h0, pos);
    feedback_source_select = FB_AI1;
    tick(4);
  endtask

  task automatic t_misc;
    logic a;
    proportional_gain = '0;
    integral_gain = 8'h10;
    integral_bypass = 1'h1;
    tick(4);
    check("bypass", 16'h0000, speed_reference);
    integral_bypass = 1'h0;
    tick(4);
    check("integ", 1'h1, pos);
    proportional_gain = 8'h10;
    integral_gain = '0;
    tick(3);
    a = feedback_alarm;
    feedback_alarm_level = 16'h7FFF;
    tick(3);
    check("fb_alarm", 1'h1, a ^ feedback_alarm);
    a = error_alarm;
    error_alarm_level = 16'h7FFF;
    tick(3);
    check("err_alarm", 1'h1, a ^ error_alarm);
    manual_mode = 1'h0;
    preset_speed = 16'h1234;
    tick(3);
    check("auto", 16'h1234, speed_reference);
    manual_mode = 1'h1;
    // stale integral would offset the manual reference
    integral_bypass = 1'h1;
    level = HI;
    manual_reference_source = 16'h0100;
    tick(4);
    check("manual", 16'h0100, speed_reference);
  endtask

  task automatic t_sleep;
    int a;
    manual_reference_source = '0;
    await(1, 1'h1);
    check("asleep", 16'h0000, speed_reference);
    a = n_accel;
    level = 16'h0370;
    tick(10);
    check("doze", 1'h1, sleeping);
    level = 16'h0320;
    await(1, 1'h0);
    tick(2);
    check("wake", 1'h1, n_accel > a);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'h1;
    tick(3);
    t_scale();
    t_sources();
    t_start();
    t_signs();
    t_network();
    t_misc();
    t_sleep();
    wrap_up();
  end
endmodule
